// ==== core/iec_clear_bank.sv ====
// Event request latches with write-one-to-clear registers, masks and an AXI4-Lite slave.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`include "iec_params.svh"

module iec_clear_bank
   import iec_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire iec_evt_s event_pulse,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);

   localparam logic [15:0] IDX_TABLE [9] = '{
      `IEC_IDX_SYSTEM_CLOCK, `IEC_IDX_COMP_LOOP, `IEC_IDX_REF_PAIR_A, `IEC_IDX_REF_PAIR_B,
      `IEC_IDX_CH0_LOCK, `IEC_IDX_CH0_STATE, `IEC_IDX_CH0_FAST_ACQ, `IEC_IDX_CH0_PROFILE,
      `IEC_IDX_CH0_ANALOG};
   localparam logic [7:0] VALID_TABLE [9] = '{
      `IEC_VALID_SYSTEM_CLOCK, `IEC_VALID_COMP_LOOP, `IEC_VALID_REF_PAIR_A,
      `IEC_VALID_REF_PAIR_B, `IEC_VALID_CH0_LOCK, `IEC_VALID_CH0_STATE,
      `IEC_VALID_CH0_FAST_ACQ, `IEC_VALID_CH0_PROFILE, `IEC_VALID_CH0_ANALOG};

   // Slot of a request register (clear view) for a byte address, or none.
   function automatic logic [3:0] clear_slot(input logic [ADDR_W-1:0] addr);
      logic [3:0] slot;
      slot = `IEC_SLOT_NONE;
      if (addr[1:0] == 2'h0) begin
         for (int i = 0; i < 9; i++) begin
            if (ADDR_W'({IDX_TABLE[i], 2'h0}) == addr) begin
               slot = 4'(i);
            end
         end
      end
      return slot;
   endfunction

   // Slot of a mask register for a byte address, or none.
   function automatic logic [3:0] mask_slot(input logic [ADDR_W-1:0] addr);
      logic [3:0] slot;
      slot = `IEC_SLOT_NONE;
      if (addr[1:0] == 2'h0) begin
         for (int i = 0; i < 9; i++) begin
            if (ADDR_W'({16'(IDX_TABLE[i] + `IEC_MASK_IDX_STEP), 2'h0}) == addr) begin
               slot = 4'(i);
            end
         end
      end
      return slot;
   endfunction

   iec_bank_t evt_bytes;
   iec_bank_t req_reg;
   iec_bank_t req_next;
   iec_bank_t mask_reg;
   iec_bank_t clr_bits;

   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic irq_reg;

   logic aw_held_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic w_held_reg;
   logic [7:0] w_byte_reg;
   logic w_lane0_reg;

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic do_wr;
   logic [3:0] wr_clear_slot;
   logic [3:0] wr_mask_slot;
   logic [3:0] rd_clear_slot;
   logic [3:0] rd_mask_slot;

   assign evt_bytes[0] = event_pulse.system_clock;
   assign evt_bytes[1] = event_pulse.compensation_loop;
   assign evt_bytes[2] = event_pulse.ref_input_a;
   assign evt_bytes[3] = event_pulse.ref_input_b;
   assign evt_bytes[4] = event_pulse.digital_loop_0_lock;
   assign evt_bytes[5] = event_pulse.digital_loop_0_state;
   assign evt_bytes[6] = event_pulse.digital_loop_0_fast_acq;
   assign evt_bytes[7] = event_pulse.digital_loop_0_profile;
   assign evt_bytes[8] = event_pulse.analog_loop_0;

   assign aw_fire = s_axi_awvalid && awready_reg;
   assign w_fire = s_axi_wvalid && wready_reg;
   assign ar_fire = s_axi_arvalid && arready_reg;
   assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_clear_slot = clear_slot(aw_addr_reg);
   assign wr_mask_slot = mask_slot(aw_addr_reg);
   assign rd_clear_slot = clear_slot(s_axi_araddr);
   assign rd_mask_slot = mask_slot(s_axi_araddr);

   // Every check below runs on the bus clock and sleeps through reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Write address and data are taken in either order, one write at a time.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (aw_fire) begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wready_reg <= 1'b0;
         w_held_reg <= 1'b0;
         w_byte_reg <= `IEC_RESET_BYTE;
         w_lane0_reg <= 1'b0;
      end else if (w_fire) begin
         wready_reg <= 1'b0;
         w_held_reg <= 1'b1;
         w_byte_reg <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end else if (do_wr) begin
         w_held_reg <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
         wready_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `IEC_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_reg <= 1'b1;
         if (wr_clear_slot == `IEC_SLOT_NONE && wr_mask_slot == `IEC_SLOT_NONE) begin
            bresp_reg <= `IEC_RESP_SLVERR;
         end else begin
            bresp_reg <= `IEC_RESP_OKAY;
         end
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Ones written to a clear register, limited to implemented bits.
   always_comb begin
      for (int s = 0; s < 9; s++) begin
         clr_bits[s] = 8'h00;
         if (do_wr && w_lane0_reg && wr_clear_slot == 4'(s)) begin
            clr_bits[s] = w_byte_reg & VALID_TABLE[s];
         end
      end
   end

   // An event in the same cycle as its clear keeps the request set.
   generate
      for (genvar s = 0; s < 9; s++) begin : g_slot
         assign req_next[s] = ((req_reg[s] & ~clr_bits[s]) | evt_bytes[s])
            & VALID_TABLE[s];

         always_ff @(posedge clk) begin
            if (sys_rst) begin
               req_reg[s] <= `IEC_RESET_BYTE;
            end else begin
               req_reg[s] <= req_next[s];
            end
         end

         always_ff @(posedge clk) begin
            if (sys_rst) begin
               mask_reg[s] <= `IEC_RESET_BYTE;
            end else if (do_wr && w_lane0_reg && wr_mask_slot == 4'(s)) begin
               mask_reg[s] <= w_byte_reg & VALID_TABLE[s];
            end
         end

         chk_clear_drops_bit: assert property (
            (clr_bits[s] & ~evt_bytes[s]) != 8'h00
            |=> (req_reg[s] & $past(clr_bits[s]) & ~$past(evt_bytes[s])) == 8'h00)
            else $error("cleared request bit still set");
         chk_event_wins: assert property (
            evt_bytes[s] != 8'h00
            |=> (req_reg[s] & $past(evt_bytes[s]) & VALID_TABLE[s])
               == ($past(evt_bytes[s]) & VALID_TABLE[s]))
            else $error("event lost on clear");
         chk_zero_write_keeps: assert property (
            1'b1 |=> ($past(req_reg[s]) & ~$past(clr_bits[s]) & ~req_reg[s]) == 8'h00)
            else $error("request dropped without a one written");
         chk_reserved_zero: assert property (
            (req_reg[s] & ~VALID_TABLE[s]) == 8'h00 && (mask_reg[s] & ~VALID_TABLE[s]) == 8'h00)
            else $error("reserved bit set");
         chk_mask_lands: assert property (
            do_wr && w_lane0_reg && wr_mask_slot == 4'(s)
            |=> mask_reg[s] == ($past(w_byte_reg) & VALID_TABLE[s]))
            else $error("mask write did not land");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arready_reg <= 1'b0;
      end else if (ar_fire) begin
         arready_reg <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // Clear registers read back the latched requests; masks read back the written implemented bits.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= `IEC_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `IEC_RESP_OKAY;
         if (rd_clear_slot != `IEC_SLOT_NONE) begin
            rdata_reg <= {24'h000000, req_reg[rd_clear_slot]};
         end else if (rd_mask_slot != `IEC_SLOT_NONE) begin
            rdata_reg <= {24'h000000, mask_reg[rd_mask_slot]};
         end else begin
            rdata_reg <= '0;
            rresp_reg <= `IEC_RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(req_reg & mask_reg);
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign irq = irq_reg;

   sequence write_both_held;
      aw_held_reg && w_held_reg && !bvalid_reg;
   endsequence

   sequence response_up;
      bvalid_reg ##1 (bvalid_reg || $past(s_axi_bready));
   endsequence

   sequence response_taken;
      bvalid_reg && s_axi_bready;
   endsequence

   sequence readies_back;
      ##1 (awready_reg && wready_reg);
   endsequence

   chk_write_answer: assert property (write_both_held |=> response_up)
      else $error("write response missing after address and data");
   chk_read_answer: assert property (ar_fire |=> rvalid_reg)
      else $error("read data not returned one cycle after address");
   chk_read_returns_req: assert property (
      ar_fire && rd_clear_slot == 4'h0 |=> rdata_reg[7:0] == $past(req_reg[0]))
      else $error("system clock clear register misread");
   chk_irq_follows: assert property (1'b1 |=> irq_reg == |($past(req_reg) & $past(mask_reg)))
      else $error("interrupt output does not follow masked requests");
   chk_one_write: assert property (bvalid_reg |-> !awready_reg && !wready_reg)
      else $error("new write accepted while response pending");
   chk_watchdog_clear: assert property (
      clr_bits[0][2] && !evt_bytes[0][2] |=> !req_reg[0][2])
      else $error("watchdog request not cleared");
   chk_state_bit1_reserved: assert property (!req_reg[5][1] && !mask_reg[5][1])
      else $error("channel 0 state bit 1 set");
   chk_neighbour_kept: assert property (
      clr_bits[1] == 8'h20 && req_reg[1][4] |=> req_reg[1][4])
      else $error("temperature request lost on skew clear");
   chk_write_readies_back: assert property (response_taken |=> readies_back)
      else $error("write channels not reopened after the response");
   chk_read_ready_back: assert property (rvalid_reg && s_axi_rready |=> ##1 arready_reg)
      else $error("read address channel not reopened");
   chk_unmapped_write: assert property (
      do_wr && wr_clear_slot == `IEC_SLOT_NONE && wr_mask_slot == `IEC_SLOT_NONE
      |=> bresp_reg == `IEC_RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_rdata_upper_zero: assert property (rvalid_reg |-> rdata_reg[31:8] == 24'h000000)
      else $error("read data carries bits above the byte");
   chk_lane_gated: assert property (do_wr && !w_lane0_reg |-> clr_bits == '0)
      else $error("write without byte lane 0 cleared a request");

   // Single-bit clears, one for each of eleven request bits, with no event in the same cycle.
   chk_sys_cal_clear: assert property (
      clr_bits[0][4] && !evt_bytes[0][4] |=> !req_reg[0][4])
      else $error("calibration ended request not cleared");
   chk_nvm_fault_clear: assert property (
      clr_bits[0][1] && !evt_bytes[0][1] |=> !req_reg[0][1])
      else $error("nonvolatile memory fault request not cleared");
   chk_comp_fault_clear: assert property (
      clr_bits[1][2] && !evt_bytes[1][2] |=> !req_reg[1][2])
      else $error("compensation loop faulted request not cleared");
   chk_comp_lock_clear: assert property (
      clr_bits[1][0] && !evt_bytes[1][0] |=> !req_reg[1][0])
      else $error("compensation loop locked request not cleared");
   chk_ref_pair_a_clear: assert property (
      clr_bits[2][7] && !evt_bytes[2][7] |=> !req_reg[2][7])
      else $error("pair A complementary resync request not cleared");
   chk_ref_a_primary_clear: assert property (
      clr_bits[2][3] && !evt_bytes[2][3] |=> !req_reg[2][3])
      else $error("pair A primary resync request not cleared");
   chk_ref_pair_b_clear: assert property (
      clr_bits[3][6] && !evt_bytes[3][6] |=> !req_reg[3][6])
      else $error("pair B complementary validated request not cleared");
   chk_ref_b_primary_clear: assert property (
      clr_bits[3][0] && !evt_bytes[3][0] |=> !req_reg[3][0])
      else $error("pair B primary faulted request not cleared");
   chk_fast_acq_clear: assert property (
      clr_bits[6][3] && !evt_bytes[6][3] |=> !req_reg[6][3])
      else $error("acquisition completed request not cleared");
   chk_profile_clear: assert property (
      clr_bits[7][5] && !evt_bytes[7][5] |=> !req_reg[7][5])
      else $error("profile 5 request not cleared");
   chk_analog_clear: assert property (
      clr_bits[8][0] && !evt_bytes[8][0] |=> !req_reg[8][0])
      else $error("analog loop calibration start request not cleared");

endmodule // iec_clear_bank

// ==== core/iec_params.svh ====
// Register indices, field masks, reset values and bus codes for the event clear bank.
// Function
// - Write 1 to bits 7..5 of system clock clear drops unlocked, stabilized, locked.
// - Bits 4 and 3 of system clock clear drop calibration ended and started.
// - Bit 2 of system clock clear drops the watchdog timeout request.
// - Bits 1 and 0 drop nonvolatile memory fault and operation completed requests.
// - Compensation loop clear bit 5 drops skew limit request; bits 7..6 read zero.
// - Compensation loop clear bit 4 drops the temperature warning request.
// - Compensation loop clear bits 3 and 2 drop unfaulted and faulted requests.
// - Compensation loop clear bits 1 and 0 drop unlocked and locked requests.
// - Pair A clear bits 7..4 drop complementary input resync, valid, unfault, fault.
// - Pair A clear bits 3..0 drop primary input resync, valid, unfault, fault.
// - Pair B clear bits 7..4 drop complementary input resync, valid, unfault, fault.
// - Pair B clear bits 3..0 drop primary input resync, valid, unfault, fault.
// - Channel 0 lock and state clear registers exist; state bit 1 reserved.
// - Channel 0 acquisition, profile and analog loop registers exist, resetting to zero.
// - Every common clear bit resets to zero and is readable and writable.
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH

`define IEC_IDX_SYSTEM_CLOCK 16'h2006
`define IEC_IDX_COMP_LOOP 16'h2007
`define IEC_IDX_REF_PAIR_A 16'h2008
`define IEC_IDX_REF_PAIR_B 16'h2009
`define IEC_IDX_CH0_LOCK 16'h200B
`define IEC_IDX_CH0_STATE 16'h200C
`define IEC_IDX_CH0_FAST_ACQ 16'h200D
`define IEC_IDX_CH0_PROFILE 16'h200E
`define IEC_IDX_CH0_ANALOG 16'h200F
`define IEC_MASK_IDX_STEP 16'h0100

`define IEC_VALID_SYSTEM_CLOCK 8'hFF
`define IEC_VALID_COMP_LOOP 8'h3F
`define IEC_VALID_REF_PAIR_A 8'hFF
`define IEC_VALID_REF_PAIR_B 8'hFF
`define IEC_VALID_CH0_LOCK 8'hFF
`define IEC_VALID_CH0_STATE 8'hFD
`define IEC_VALID_CH0_FAST_ACQ 8'h1C
`define IEC_VALID_CH0_PROFILE 8'h3F
`define IEC_VALID_CH0_ANALOG 8'h1F

`define IEC_RESET_BYTE 8'h00
`define IEC_SLOT_NONE 4'hF
`define IEC_RESP_OKAY 2'h0
`define IEC_RESP_SLVERR 2'h2

`endif

// ==== core/iec_pkg.sv ====
// Types shared by the event clear bank.
package iec_pkg;

   // One event pulse per request bit, grouped by clear register.
   typedef struct packed {
      logic [7:0] system_clock;
      logic [7:0] compensation_loop;
      logic [7:0] ref_input_a;
      logic [7:0] ref_input_b;
      logic [7:0] digital_loop_0_lock;
      logic [7:0] digital_loop_0_state;
      logic [7:0] digital_loop_0_fast_acq;
      logic [7:0] digital_loop_0_profile;
      logic [7:0] analog_loop_0;
   } iec_evt_s;

   typedef logic [8:0][7:0] iec_bank_t;

endpackage

// ==== verification/iec_clear_bank_bench.sv ====
// Self-checking bench for the event clear bank over its AXI4-Lite port.
`timescale 1ns/100ps
`include "iec_params.svh"

module iec_clear_bank_bench import iec_pkg::*; ;
   localparam logic [15:0] IDX [9] = '{`IEC_IDX_SYSTEM_CLOCK, `IEC_IDX_COMP_LOOP,
      `IEC_IDX_REF_PAIR_A, `IEC_IDX_REF_PAIR_B, `IEC_IDX_CH0_LOCK, `IEC_IDX_CH0_STATE,
      `IEC_IDX_CH0_FAST_ACQ, `IEC_IDX_CH0_PROFILE, `IEC_IDX_CH0_ANALOG};
   localparam logic [7:0] VLD [9] = '{`IEC_VALID_SYSTEM_CLOCK, `IEC_VALID_COMP_LOOP,
      `IEC_VALID_REF_PAIR_A, `IEC_VALID_REF_PAIR_B, `IEC_VALID_CH0_LOCK,
      `IEC_VALID_CH0_STATE, `IEC_VALID_CH0_FAST_ACQ, `IEC_VALID_CH0_PROFILE,
      `IEC_VALID_CH0_ANALOG};
   logic clk, sys_rst;
   logic [71:0] evt_bits;
   logic [15:0] s_axi_awaddr, s_axi_araddr, lfsr_q;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [1:0] exp_b [$];
   logic [33:0] exp_r [$];
   logic [7:0] p;
   int errors, checks_done;

   iec_clear_bank dut (.clk(clk), .sys_rst(sys_rst), .event_pulse(iec_evt_s'(evt_bits)),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [15:0] lfsr_step(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic cmp(input string what, input logic [33:0] exp, input logic [33:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Writes a byte; the expected response is noted for the monitor.
   task automatic axi_write(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
      int n;
      bit done;
      exp_b.push_back(r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {lfsr_q, 8'h00, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      done = 0;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) done = 1;
      end
      s_axi_bready <= 1'b0;
      if (!done) errors++;
   endtask

   task automatic axi_read(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
      int n;
      bit done;
      exp_r.push_back({r, 24'h0, d});
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      done = 0;
      while (!done && n < 100) begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) done = 1;
      end
      s_axi_rready <= 1'b0;
      if (!done) errors++;
   endtask

   task automatic fire(input int i, input logic [7:0] v);
      @(posedge clk);
      evt_bits[(8-i)*8 +: 8] <= v;
      @(posedge clk);
      evt_bits <= '0;
   endtask

   task automatic irq_is(input logic v);
      repeat (2) @(posedge clk);
      cmp("irq", {33'h0, v}, {33'h0, irq});
   endtask

   always @(posedge clk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         cmp("bresp", {32'h0, exp_b.size() ? exp_b.pop_front() : 2'bxx}, {32'h0, s_axi_bresp});
      end
      if (s_axi_rvalid && s_axi_rready) begin
         cmp("read", exp_r.size() ? exp_r.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      give_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      evt_bits = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      lfsr_q = 16'hC43C;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         axi_read(IDX[i] << 2, 8'h00, `IEC_RESP_OKAY);
         axi_read((IDX[i] + `IEC_MASK_IDX_STEP) << 2, 8'h00, `IEC_RESP_OKAY);
      end
      $display("test reset values done");
      for (int i = 0; i < 9; i++) begin
         fire(i, 8'hFF);
         axi_read(IDX[i] << 2, VLD[i], `IEC_RESP_OKAY);
         lfsr_q = lfsr_step(lfsr_q);
         p = lfsr_q[7:0];
         axi_write(IDX[i] << 2, p, `IEC_RESP_OKAY);
         axi_read(IDX[i] << 2, VLD[i] & ~p, `IEC_RESP_OKAY);
         axi_write(IDX[i] << 2, 8'h00, `IEC_RESP_OKAY);
         axi_read(IDX[i] << 2, VLD[i] & ~p, `IEC_RESP_OKAY);
         axi_write(IDX[i] << 2, 8'hFF, `IEC_RESP_OKAY);
         axi_read(IDX[i] << 2, 8'h00, `IEC_RESP_OKAY);
      end
      $display("test set and clear done");
      fire(0, 8'hFF);
      @(posedge clk);
      evt_bits[66] <= 1'b1;
      axi_write(IDX[0] << 2, 8'hFF, `IEC_RESP_OKAY);
      evt_bits[66] <= 1'b0;
      axi_read(IDX[0] << 2, 8'h04, `IEC_RESP_OKAY);
      s_axi_wstrb <= 4'hE;
      axi_write(IDX[0] << 2, 8'h04, `IEC_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_read(IDX[0] << 2, 8'h04, `IEC_RESP_OKAY);
      axi_write(IDX[0] << 2, 8'h04, `IEC_RESP_OKAY);
      axi_read(IDX[0] << 2, 8'h00, `IEC_RESP_OKAY);
      fire(1, 8'h30);
      axi_write(IDX[1] << 2, 8'h20, `IEC_RESP_OKAY);
      axi_read(IDX[1] << 2, 8'h10, `IEC_RESP_OKAY);
      axi_write((IDX[6] + `IEC_MASK_IDX_STEP) << 2, 8'hFF, `IEC_RESP_OKAY);
      axi_read((IDX[6] + `IEC_MASK_IDX_STEP) << 2, VLD[6], `IEC_RESP_OKAY);
      $display("test clear collision done");
      fire(3, 8'h20);
      axi_write((IDX[3] + `IEC_MASK_IDX_STEP) << 2, 8'h10, `IEC_RESP_OKAY);
      irq_is(1'b0);
      axi_write((IDX[3] + `IEC_MASK_IDX_STEP) << 2, 8'h20, `IEC_RESP_OKAY);
      irq_is(1'b1);
      axi_write(IDX[3] << 2, 8'h20, `IEC_RESP_OKAY);
      irq_is(1'b0);
      $display("test interrupt done");
      axi_write(16'h8000, 8'hFF, `IEC_RESP_SLVERR);
      axi_read(16'h8000, 8'h00, `IEC_RESP_SLVERR);
      @(posedge clk);
      $display("test unmapped done");
      give_verdict();
   end
endmodule // iec_clear_bank_bench
